// ---- rtl/supply_monitor_flag_logic.sv ----
// module: apb-controlled supply monitor flag, hold-off timer and interrupt
`timescale 1ns/1ns
module supply_monitor_flag_logic #(
	parameter int unsigned HOLD_CYCLES = supply_pkg::HOLD_CYCLES_DEF // 250 ms hold-off in clocks
) (
	input  wire logic                              pclk,        // apb clock, 100 MHz
	input  wire logic                              presetn,     // async reset, active low
	input  wire logic                              psel,        // apb select
	input  wire logic                              penable,     // apb enable
	input  wire logic                              pwrite,      // apb direction
	input  wire logic [supply_pkg::ADDR_W-1:0]     paddr,       // apb byte address
	input  wire logic [supply_pkg::DATA_W-1:0]     pwdata,      // apb write data
	output logic      [supply_pkg::DATA_W-1:0]     prdata,      // apb read data
	output logic                                   pready,      // apb ready
	output logic                                   pslverr,     // apb error on unmapped address
	input  wire logic                              dvdd_ok_i,   // digital supply comparator, 1 above trip
	input  wire logic                              avdd_ok_i,   // analog supply comparator, 1 above trip
	output supply_pkg::ana_ctrl_t                  ana_ctrl_o,  // enable and trip select to comparator
	output logic                                   low_flag_o,  // sticky low-supply flag
	output logic                                   irq_o        // level interrupt
);

	supply_pkg::mon_regs_t s_q;
	supply_pkg::mon_regs_t s_d;

	function automatic supply_pkg::filt_t filt_step(
		input supply_pkg::filt_t f,
		input logic              raw,
		input logic              en
	);
		supply_pkg::filt_t r;
		r = f;
		if (!en) begin
			r.lvl = 1'b1;
			r.cnt = '0;
		end else if (raw == f.lvl) begin
			r.cnt = '0;
		end else if (f.cnt == supply_pkg::GLITCH_W'(supply_pkg::GLITCH_CYCLES - 1)) begin
			r.lvl = raw;
			r.cnt = '0;
		end else begin
			r.cnt = f.cnt + 1'b1;
		end
		return r;
	endfunction

	function automatic logic [1:0] reg_sel(input logic [supply_pkg::ADDR_W-1:0] a);
		if (a == supply_pkg::CTRL_ADDR) begin
			return 2'h1;
		end else if (a == supply_pkg::EVT_ADDR) begin
			return 2'h2;
		end else if (a == supply_pkg::MASK_ADDR) begin
			return 2'h3;
		end
		return 2'h0;
	endfunction

	logic                          setup;
	logic                          wr;
	logic [1:0]                    sel;
	logic                          low;
	logic                          entry;
	logic                          recov;
	logic [7:0]                    ctrl_rd;
	logic [supply_pkg::DATA_W-1:0] rd_mux;

	assign setup = psel & ~penable;
	assign wr    = psel & penable & s_q.pready & pwrite;
	assign sel   = reg_sel(paddr);
	// both filtered levels count: the analog rail failing also blocks clearing
	assign low   = ~s_q.dv.lvl | ~s_q.av.lvl;

	always_comb begin
		ctrl_rd                             = supply_pkg::CTRL_RESET & supply_pkg::RSVD_MASK;
		ctrl_rd[supply_pkg::EN_BIT]         = s_q.en;
		ctrl_rd[supply_pkg::TRIP_HI:supply_pkg::TRIP_LO] = s_q.trip;
		ctrl_rd[supply_pkg::FLAG_BIT]       = s_q.flag;
		// unfiltered on purpose so software sees the comparator as it is now
		ctrl_rd[supply_pkg::CMP_BIT]        = dvdd_ok_i;
		rd_mux = '0;
		unique case (sel)
			2'h1: rd_mux[7:0] = ctrl_rd;
			2'h2: rd_mux[supply_pkg::EVT_W-1:0] = s_q.evt;
			2'h3: rd_mux[supply_pkg::EVT_W-1:0] = s_q.mask;
			2'h0: rd_mux = '0;
		endcase
	end

	always_comb begin
		s_d         = s_q;
		s_d.pready  = 1'b0;
		s_d.pslverr = 1'b0;
		entry       = 1'b0;
		recov       = 1'b0;

		// zero-wait slave: data and ready set up in the setup cycle
		if (setup) begin
			s_d.pready  = 1'b1;
			s_d.prdata  = rd_mux;
			s_d.pslverr = (sel == 2'h0);
		end

		s_d.dv = filt_step(s_q.dv, dvdd_ok_i, s_q.en);
		s_d.av = filt_step(s_q.av, avdd_ok_i, s_q.en);

		unique case (s_q.st)
			supply_pkg::ST_IDLE: begin
				s_d.hold = '0;
				if (low) begin
					s_d.st = supply_pkg::ST_LOW;
					entry  = 1'b1;
				end
			end
			supply_pkg::ST_LOW: begin
				s_d.hold = '0;
				if (!low) begin
					s_d.st = supply_pkg::ST_HOLD;
				end
			end
			supply_pkg::ST_HOLD: begin
				if (low) begin
					s_d.st   = supply_pkg::ST_LOW;
					s_d.hold = '0;
				end else if (s_q.hold == supply_pkg::HOLD_W'(HOLD_CYCLES - 1)) begin
					s_d.st   = supply_pkg::ST_IDLE;
					s_d.hold = '0;
					s_d.flag = 1'b0;
					recov    = 1'b1;
				end else begin
					s_d.hold = s_q.hold + 1'b1;
				end
			end
			default: begin
				s_d.st   = supply_pkg::ST_IDLE;
				s_d.hold = '0;
			end
		endcase

		// a disabled monitor drops any count in progress but keeps the flag
		if (!s_q.en) begin
			s_d.st   = supply_pkg::ST_IDLE;
			s_d.hold = '0;
		end

		if (wr) begin
			unique case (sel)
				2'h1: begin
					s_d.en   = pwdata[supply_pkg::EN_BIT];
					s_d.trip = pwdata[supply_pkg::TRIP_HI:supply_pkg::TRIP_LO];
					if (pwdata[supply_pkg::FLAG_BIT]) begin
						s_d.flag = 1'b1;
					end else if (!low) begin
						s_d.flag = 1'b0;
					end
				end
				2'h2: s_d.evt  = s_q.evt & ~pwdata[supply_pkg::EVT_W-1:0];
				2'h3: s_d.mask = pwdata[supply_pkg::EVT_W-1:0];
				2'h0: s_d.evt  = s_q.evt;
			endcase
		end

		// hardware sets come last so they win over a same-cycle clear
		if (low) begin
			s_d.flag = 1'b1;
		end
		if (entry) begin
			s_d.evt[supply_pkg::EVT_LOW] = 1'b1;
		end
		if (recov) begin
			s_d.evt[supply_pkg::EVT_RECOV] = 1'b1;
		end

		s_d.irq = |(s_d.evt & s_d.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q.en      <= supply_pkg::CTRL_RESET[supply_pkg::EN_BIT];
			s_q.trip    <= supply_pkg::CTRL_RESET[supply_pkg::TRIP_HI:supply_pkg::TRIP_LO];
			s_q.flag    <= supply_pkg::CTRL_RESET[supply_pkg::FLAG_BIT];
			s_q.dv      <= '{lvl: 1'b1, cnt: '0};
			s_q.av      <= '{lvl: 1'b1, cnt: '0};
			s_q.st      <= supply_pkg::ST_IDLE;
			s_q.hold    <= '0;
			s_q.evt     <= supply_pkg::EVT_RESET;
			s_q.mask    <= supply_pkg::MASK_RESET;
			s_q.irq     <= 1'b0;
			s_q.pready  <= 1'b0;
			s_q.pslverr <= 1'b0;
			s_q.prdata  <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata     = s_q.prdata;
	assign pready     = s_q.pready;
	assign pslverr    = s_q.pslverr;
	assign ana_ctrl_o = '{enable: s_q.en, trip_sel: s_q.trip};
	assign low_flag_o = s_q.flag;
	assign irq_o      = s_q.irq;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic ctrl_wr;
	assign ctrl_wr = wr && (sel == 2'h1);

	property p_enable_write;
		ctrl_wr |=> (ana_ctrl_o.enable == $past(pwdata[supply_pkg::EN_BIT]));
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable bit not taken from write");

	property p_trip_write;
		ctrl_wr |=> (ana_ctrl_o.trip_sel == $past(pwdata[supply_pkg::TRIP_HI:supply_pkg::TRIP_LO]));
	endproperty
	a_trip_write: assert property (p_trip_write) else $error("trip select not taken from write");

	property p_cmp_live;
		(setup && sel == 2'h1) |=> (prdata[supply_pkg::CMP_BIT] == $past(dvdd_ok_i));
	endproperty
	a_cmp_live: assert property (p_cmp_live) else $error("comparator bit not live");

	property p_low_sets_flag;
		(s_q.en && !s_q.dv.lvl) |=> low_flag_o;
	endproperty
	a_low_sets_flag: assert property (p_low_sets_flag) else $error("low supply did not set flag");

	property p_hold_clear;
		(s_q.st == supply_pkg::ST_HOLD && s_q.en && !low && !ctrl_wr
			&& s_q.hold == supply_pkg::HOLD_W'(HOLD_CYCLES - 1)) |=> !low_flag_o;
	endproperty
	a_hold_clear: assert property (p_hold_clear) else $error("flag not cleared at hold-off end");

	property p_no_early_clear;
		(low_flag_o && !ctrl_wr) ##1 !low_flag_o |-> $past(s_q.st) == supply_pkg::ST_HOLD;
	endproperty
	a_no_early_clear: assert property (p_no_early_clear) else $error("flag cleared outside hold-off");

	property p_sw_set;
		(ctrl_wr && pwdata[supply_pkg::FLAG_BIT]) |=> low_flag_o;
	endproperty
	a_sw_set: assert property (p_sw_set) else $error("software set of flag lost");

	property p_clear_blocked;
		(ctrl_wr && !pwdata[supply_pkg::FLAG_BIT] && low) |=> low_flag_o;
	endproperty
	a_clear_blocked: assert property (p_clear_blocked) else $error("flag cleared during low supply");

	property p_irq_gated;
		irq_o == |(s_q.evt & s_q.mask);
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("interrupt without enabled source");

	property p_glitch;
		$fell(s_q.dv.lvl) |-> $past(!dvdd_ok_i, 1) && $past(!dvdd_ok_i, 2);
	endproperty
	a_glitch: assert property (p_glitch) else $error("short glitch passed the filter");

	property p_restart;
		(s_q.st == supply_pkg::ST_HOLD && low && s_q.en) |=> (s_q.hold == '0) && low_flag_o;
	endproperty
	a_restart: assert property (p_restart) else $error("hold-off not restarted on new low");

	property p_reserved;
		(setup && sel == 2'h1) |=> (prdata[7:0] & supply_pkg::RSVD_MASK)
			== (supply_pkg::CTRL_RESET & supply_pkg::RSVD_MASK);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits read wrong");

	property p_ready_one;
		setup |=> pready ##1 !pready;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("pready not a single cycle");

	c_low_event: cover property (s_q.en && $fell(s_q.dv.lvl) ##[1:8] low_flag_o);
	c_hold_done: cover property (s_q.st == supply_pkg::ST_HOLD ##1 s_q.st == supply_pkg::ST_IDLE);
	c_hold_abort: cover property (s_q.st == supply_pkg::ST_HOLD ##1 s_q.st == supply_pkg::ST_LOW);
	c_irq: cover property ($rose(irq_o));

endmodule // supply_monitor_flag_logic

// ---- rtl/supply_pkg.sv ----
// package: register map, timing constants and state types of the supply monitor
//
// What this block does
// - enable bit 0 switches monitor on/off
// - bits 4:3 pick one of four trips
// - bit 6 reads live comparator, writes ignored
// - comparator bit 1 above trip, 0 below
// - low comparator sets sticky flag bit 5
// - flag auto-clears after 250 ms high following a low
// - software may write the flag
// - flag clear ignored while any comparator low
// - interrupt only when its enable is set
// - glitch filter keeps spikes from setting flag
package supply_pkg;

	localparam int unsigned ADDR_W    = 12;
	localparam int unsigned DATA_W    = 32;

	// register indexes; byte address is four times the index
	localparam logic [7:0]        CTRL_IDX  = 8'hDF;
	localparam logic [7:0]        EVT_IDX   = 8'hE0;
	localparam logic [7:0]        MASK_IDX  = 8'hE1;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] EVT_ADDR  = {2'h0, EVT_IDX, 2'h0};
	localparam logic [ADDR_W-1:0] MASK_ADDR = {2'h0, MASK_IDX, 2'h0};

	// control register layout
	localparam int unsigned EN_BIT    = 0;
	localparam int unsigned TRIP_LO   = 3;
	localparam int unsigned TRIP_HI   = 4;
	localparam int unsigned FLAG_BIT  = 5;
	localparam int unsigned CMP_BIT   = 6;
	localparam logic [7:0]  CTRL_RESET = 8'hDE;
	localparam logic [7:0]  RSVD_MASK  = 8'h86;

	// trip select codes: 4.37 V, 3.08 V, 2.93 V, 2.63 V
	localparam logic [1:0] TRIP_4V37 = 2'h0;
	localparam logic [1:0] TRIP_3V08 = 2'h1;
	localparam logic [1:0] TRIP_2V93 = 2'h2;
	localparam logic [1:0] TRIP_2V63 = 2'h3;

	// event status / mask layout
	localparam int unsigned EVT_W     = 2;
	localparam int unsigned EVT_LOW   = 0;
	localparam int unsigned EVT_RECOV = 1;
	localparam logic [EVT_W-1:0] EVT_RESET  = 2'h0;
	localparam logic [EVT_W-1:0] MASK_RESET = 2'h0;

	// timing
	localparam int unsigned CLK_KHZ         = 100000;
	localparam int unsigned HOLD_MS         = 250;
	localparam int unsigned HOLD_CYCLES_DEF = HOLD_MS * CLK_KHZ;
	localparam int unsigned HOLD_W          = 25;
	localparam int unsigned GLITCH_NS       = 1000;
	localparam int unsigned GLITCH_CYCLES   = (GLITCH_NS * CLK_KHZ + 999999) / 1000000;
	localparam int unsigned GLITCH_W        = 7;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LOW  = 2'h1,
		ST_HOLD = 2'h3
	} mon_state_t;

	typedef struct packed {
		logic                lvl;
		logic [GLITCH_W-1:0] cnt;
	} filt_t;

	typedef struct packed {
		logic       enable;
		logic [1:0] trip_sel;
	} ana_ctrl_t;

	typedef struct packed {
		logic              en;
		logic [1:0]        trip;
		logic              flag;
		filt_t             dv;
		filt_t             av;
		mon_state_t        st;
		logic [HOLD_W-1:0] hold;
		logic [EVT_W-1:0]  evt;
		logic [EVT_W-1:0]  mask;
		logic              irq;
		logic              pready;
		logic              pslverr;
		logic [DATA_W-1:0] prdata;
	} mon_regs_t;

endpackage

// ---- tb/supply_comparator_model.sv ----
// model: analog supply comparators seen by the flag logic
`timescale 1ns/1ns
module supply_comparator_model (
	input  wire logic                  pclk,      // sampling clock
	input  wire supply_pkg::ana_ctrl_t ctrl,      // enable and trip select from the block
	input  wire logic                  dvdd_low,  // bench: digital supply below trip
	input  wire logic                  avdd_low,  // bench: analog supply below trip
	output logic                       dvdd_ok,   // 1 while digital supply above trip
	output logic                       avdd_ok    // 1 while analog supply above trip
);
	// the comparators keep reporting the supply even when disabled; the block must ignore them then
	initial dvdd_ok = 1'b1;
	initial avdd_ok = 1'b1;
	always @(posedge pclk) begin
		dvdd_ok <= ~dvdd_low;
		avdd_ok <= ~avdd_low;
	end
endmodule // supply_comparator_model

// ---- tb/tb_supply_monitor_flag_logic.sv ----
// testbench: apb register and flag tests of the supply monitor flag logic
`timescale 1ns/1ns
module tb_supply_monitor_flag_logic;
	localparam int unsigned HOLD = 300; // shortened hold-off, longer than the glitch filter
	logic                  pclk     = 1'b0;
	logic                  presetn  = 1'b0;
	logic                  psel     = 1'b0;
	logic                  penable  = 1'b0;
	logic                  pwrite   = 1'b0;
	logic [11:0]           paddr    = 12'h000;
	logic [31:0]           pwdata   = 32'h0;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  dvdd_low = 1'b0;
	logic                  avdd_low = 1'b0;
	logic                  dvdd_ok;
	logic                  avdd_ok;
	supply_pkg::ana_ctrl_t ana_ctrl;
	logic                  low_flag;
	logic                  irq;
	logic [31:0]           rd;
	logic                  err;
	int                    miscompares = 0;
	int                    n_checks    = 0;

	always #5 pclk = ~pclk;

	supply_monitor_flag_logic #(.HOLD_CYCLES(HOLD)) supply_monitor_flag_logic_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dvdd_ok_i(dvdd_ok), .avdd_ok_i(avdd_ok), .ana_ctrl_o(ana_ctrl),
		.low_flag_o(low_flag), .irq_o(irq));
	supply_comparator_model supply_comparator_model_i (.pclk(pclk), .ctrl(ana_ctrl), .dvdd_low(dvdd_low),
		.avdd_low(avdd_low), .dvdd_ok(dvdd_ok), .avdd_ok(avdd_ok));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one transfer, then an idle edge so outputs have settled when the caller looks
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a wait that never answers
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		#200000;
		miscompares++;
		wrap_up();
	end

	initial begin
		cyc(5);
		presetn <= 1'b1;
		rdchk(supply_pkg::CTRL_ADDR, 32'hDE);
		rdchk(supply_pkg::EVT_ADDR, 32'h0);
		rdchk(supply_pkg::MASK_ADDR, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test reset and map done");
		// zeros written to reserved bits and the live bit must not stick
		for (int t = 0; t < 4; t++) begin
			wr(supply_pkg::CTRL_ADDR, 32'h1 | (32'(t) << 3));
			rdchk(supply_pkg::CTRL_ADDR, 32'hC7 | (32'(t) << 3));
			chk(32'(ana_ctrl.trip_sel), 32'(t));
			chk({31'h0, ana_ctrl.enable}, 32'h1);
		end
		wr(supply_pkg::CTRL_ADDR, 32'h18);
		chk({31'h0, ana_ctrl.enable}, 32'h0);
		$display("test control fields done");
		dvdd_low <= 1'b1;
		cyc(150);
		chk({31'h0, low_flag}, 32'h0);
		dvdd_low <= 1'b0;
		wr(supply_pkg::CTRL_ADDR, 32'h19);
		dvdd_low <= 1'b1;
		cyc(50);
		dvdd_low <= 1'b0;
		cyc(150);
		chk({31'h0, low_flag}, 32'h0);
		$display("test disable and glitch done");
		dvdd_low <= 1'b1;
		cyc(150);
		chk({31'h0, low_flag}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		rdchk(supply_pkg::CTRL_ADDR, 32'hBF);
		rdchk(supply_pkg::EVT_ADDR, 32'h1);
		wr(supply_pkg::CTRL_ADDR, 32'h19);
		chk({31'h0, low_flag}, 32'h1);
		wr(supply_pkg::MASK_ADDR, 32'h1);
		chk({31'h0, irq}, 32'h1);
		wr(supply_pkg::EVT_ADDR, 32'h1);
		chk({31'h0, irq}, 32'h0);
		$display("test low supply done");
		dvdd_low <= 1'b0;
		cyc(250);
		avdd_low <= 1'b1;
		cyc(120);
		wr(supply_pkg::CTRL_ADDR, 32'h19);
		chk({31'h0, low_flag}, 32'h1);
		avdd_low <= 1'b0;
		cyc(350);
		chk({31'h0, low_flag}, 32'h1);
		cyc(100);
		chk({31'h0, low_flag}, 32'h0);
		apb(1'b0, supply_pkg::EVT_ADDR, 32'h0);
		chk({31'h0, rd[1]}, 32'h1);
		$display("test hold-off done");
		wr(supply_pkg::CTRL_ADDR, 32'h39);
		cyc(450);
		chk({31'h0, low_flag}, 32'h1);
		wr(supply_pkg::CTRL_ADDR, 32'h19);
		chk({31'h0, low_flag}, 32'h0);
		$display("test software flag done");
		wrap_up();
	end
endmodule // tb_supply_monitor_flag_logic
